// *** rtl/scpt_top.sv ***
`timescale 1ns/1ps
// Function
// RULE_01 - Clock control bit 15 runs seconds counter.
// RULE_02 - Seconds counter is 32-bit read/write.
// RULE_03 - Seconds write clears the sub-second prescaler.
// RULE_04 - Key 0x55CCAA33 unlocks clock registers.
// RULE_05 - Alarm is 32-bit, compared continuously.
// RULE_06 - Alarm match raises maskable request.
// RULE_07 - Alarm match resolution is one second.
// RULE_08 - Periodic bits 0:7 give request level.
// RULE_09 - Periodic flag sets at zero count.
// RULE_10 - Writing one clears periodic flag.
// RULE_11 - Periodic enable gates flag onto request.
// RULE_12 - Periodic halt bit freezes during debug.
// RULE_13 - Periodic run bit stops or decrements.
// RULE_14 - Reload is 16 bits, upper reserved.
// RULE_15 - Current count is read-only.
// RULE_16 - Periodic control clears on reset.
// RULE_17 - Alarm flag on match, tick flag per second.
// RULE_18 - Alarm and tick enables gate requests.
// RULE_19 - Slow select picks 4 or 20 MHz.
// RULE_20 - Clock flags clear by writing one.
// RULE_21 - Zero count reloads and keeps counting.
// RULE_22 - Seconds counter increments on each tick.

module scpt_top #(
    parameter int unsigned P_FAST_DIV = scpt_pkg::FAST_TICK_CYC,
    parameter int unsigned P_SLOW_DIV = scpt_pkg::SLOW_TICK_CYC,
    parameter int PIT_W = 16
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RESET,
    input wire scpt_pkg::scpt_bus_s I_BUS,
    input wire logic I_OSC_TICK,
    input wire logic I_FREEZE,
    output logic [31:0] O_RDATA,
    output scpt_pkg::scpt_irq_s O_CLK_IRQ,
    output scpt_pkg::scpt_irq_s O_PIT_IRQ
);
    import scpt_pkg::*;

    // -------------------------------------------------------------
    // Address decoding
    // -------------------------------------------------------------

    // True when a write strobe targets the given register.
    function automatic logic wr_hit(scpt_bus_s b, scpt_addr_t ofs);
        wr_hit = b.wr && (b.addr == ofs);
    endfunction

    // Open state of the key lock.
    logic unlocked_r;
    // Write strobes per register, locked ones gated by the key.
    logic wr_clk;
    logic wr_sec;
    logic wr_alarm;
    logic wr_pit_ctrl;
    logic wr_pit_reload;

    // Locked registers only accept writes while the key is open.
    assign wr_clk = wr_hit(I_BUS, CLK_CTRL_OFS) && unlocked_r; // [RULE_04]
    assign wr_sec = wr_hit(I_BUS, SEC_OFS) && unlocked_r; // [RULE_04]
    assign wr_alarm = wr_hit(I_BUS, ALARM_OFS) && unlocked_r; // [RULE_04]
    // The periodic registers are always open.
    assign wr_pit_ctrl = wr_hit(I_BUS, PIT_CTRL_OFS);
    assign wr_pit_reload = wr_hit(I_BUS, PIT_RELOAD_OFS);

    // -------------------------------------------------------------
    // Key lock
    // -------------------------------------------------------------

    // Locked after reset; the key opens, any other value closes.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            unlocked_r <= 1'b0;
        end else if (wr_hit(I_BUS, KEY_OFS)) begin
            unlocked_r <= (I_BUS.wdata == KEY_VALUE); // [RULE_04]
        end
    end

    // -------------------------------------------------------------
    // Seconds clock
    // -------------------------------------------------------------

    // Clock control word and its decoded enables.
    logic [15:0] clk_ctrl_r;
    logic clk_run;
    logic [PRE_W-1:0] pre_r;
    logic [PRE_W-1:0] pre_limit;
    logic sec_tick;
    logic [31:0] sec_r;
    logic [31:0] alarm_r;
    logic match;
    logic match_r;
    logic alarm_evt;

    // Counting stops when disabled or frozen by debug.
    assign clk_run = clk_ctrl_r[B_CLK_RUN] // [RULE_01]
        && !(clk_ctrl_r[B_CLK_HALT] && I_FREEZE);

    // The limit follows the selected oscillator rate.
    assign pre_limit = clk_ctrl_r[B_SLOW_SEL] // [RULE_19]
        ? PRE_W'(P_SLOW_DIV - 1) : PRE_W'(P_FAST_DIV - 1);

    // A compare by at-least keeps a rate change from overrunning.
    assign sec_tick = clk_run && I_OSC_TICK && (pre_r >= pre_limit);

    // Sub-second prescaler counting oscillator periods.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            pre_r <= '0;
        end else if (wr_sec) begin
            // A full second follows a time write.
            pre_r <= '0; // [RULE_03]
        end else if (clk_run && I_OSC_TICK) begin
            pre_r <= sec_tick ? '0 : pre_r + PRE_W'(1);
        end
    end

    // Seconds counter, written by software or advanced per tick.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            sec_r <= WORD_RST;
        end else if (wr_sec) begin
            sec_r <= I_BUS.wdata; // [RULE_02]
        end else if (sec_tick) begin
            sec_r <= sec_r + 32'h00000001; // [RULE_22]
        end
    end

    // Alarm value, written only while unlocked.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            alarm_r <= WORD_RST;
        end else if (wr_alarm) begin
            alarm_r <= I_BUS.wdata; // [RULE_05]
        end
    end

    // Compare on whole seconds only; the prescaler takes no part.
    assign match = (sec_r == alarm_r); // [RULE_05] [RULE_07]

    // Remember the previous compare so a standing match fires once.
    // It resets high: reset leaves both values equal, and that is no new match.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            match_r <= 1'b1;
        end else begin
            match_r <= match;
        end
    end

    // A new match is the alarm event.
    assign alarm_evt = match && !match_r; // [RULE_06]

    // Clock control word: fields on unlocked writes, flags sticky.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            clk_ctrl_r <= CTRL_RST;
        end else begin
            if (wr_clk) begin
                // Level, select, enables, halt and run follow the write.
                clk_ctrl_r[B_LEVEL_HI:B_LEVEL_LO] <=
                    I_BUS.wdata[B_LEVEL_HI:B_LEVEL_LO];
                clk_ctrl_r[B_SLOW_SEL] <= I_BUS.wdata[B_SLOW_SEL]; // [RULE_19]
                clk_ctrl_r[B_TICK_IE] <= I_BUS.wdata[B_TICK_IE];
                clk_ctrl_r[B_ALARM_IE] <= I_BUS.wdata[B_ALARM_IE];
                clk_ctrl_r[B_CLK_HALT] <= I_BUS.wdata[B_CLK_HALT];
                clk_ctrl_r[B_CLK_RUN] <= I_BUS.wdata[B_CLK_RUN]; // [RULE_01]
            end
            // Each flag clears on a written one; a new event wins.
            clk_ctrl_r[B_TICK_FLAG] <= sec_tick || (clk_ctrl_r[B_TICK_FLAG] // [RULE_17]
                && !(wr_clk && I_BUS.wdata[B_TICK_FLAG])); // [RULE_20]
            clk_ctrl_r[B_ALARM_FLAG] <= alarm_evt || (clk_ctrl_r[B_ALARM_FLAG] // [RULE_17]
                && !(wr_clk && I_BUS.wdata[B_ALARM_FLAG])); // [RULE_20]
        end
    end

    // -------------------------------------------------------------
    // Periodic timer
    // -------------------------------------------------------------

    // Periodic control word, reload value and down counter.
    logic [15:0] pit_ctrl_r;
    logic [PIT_W-1:0] pit_reload_r;
    logic [PIT_W-1:0] pit_count_r;
    logic [PIT_W-1:0] pit_count_nxt;
    logic pit_step;
    logic pit_evt;

    // One step per oscillator period while running and not frozen.
    assign pit_step = pit_ctrl_r[B_PIT_RUN] && I_OSC_TICK // [RULE_13]
        && !(pit_ctrl_r[B_PIT_HALT] && I_FREEZE); // [RULE_12]

    // A spent count reloads; otherwise the count goes down by one.
    assign pit_count_nxt = (pit_count_r == '0) // [RULE_21]
        ? pit_reload_r : pit_count_r - PIT_W'(1);

    // Arriving at zero is the periodic event.
    assign pit_evt = pit_step && (pit_count_nxt == '0); // [RULE_09]

    // Down counter; stopped it keeps its value, writes never reach it.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            pit_count_r <= '0;
        end else if (pit_step) begin
            pit_count_r <= pit_count_nxt; // [RULE_13] [RULE_15]
        end
    end

    // Reload register, upper half reserved and never stored.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            pit_reload_r <= '0;
        end else if (wr_pit_reload) begin
            pit_reload_r <= I_BUS.wdata[PIT_W-1:0]; // [RULE_14]
        end
    end

    // Periodic control word; hard reset clears every bit.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            pit_ctrl_r <= CTRL_RST; // [RULE_16]
        end else begin
            if (wr_pit_ctrl) begin
                pit_ctrl_r[B_LEVEL_HI:B_LEVEL_LO] <= // [RULE_08]
                    I_BUS.wdata[B_LEVEL_HI:B_LEVEL_LO];
                pit_ctrl_r[B_PIT_IE] <= I_BUS.wdata[B_PIT_IE]; // [RULE_11]
                pit_ctrl_r[B_PIT_HALT] <= I_BUS.wdata[B_PIT_HALT]; // [RULE_12]
                pit_ctrl_r[B_PIT_RUN] <= I_BUS.wdata[B_PIT_RUN]; // [RULE_13]
            end
            // Written one clears; an event in that cycle wins.
            pit_ctrl_r[B_PIT_FLAG] <= pit_evt || (pit_ctrl_r[B_PIT_FLAG] // [RULE_09]
                && !(wr_pit_ctrl && I_BUS.wdata[B_PIT_FLAG])); // [RULE_10]
        end
    end

    // -------------------------------------------------------------
    // Read port and request outputs
    // -------------------------------------------------------------

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET || !I_BUS.rd) begin
            O_RDATA <= WORD_RST;
        end else begin
            unique case (I_BUS.addr)
                CLK_CTRL_OFS: O_RDATA <= {16'h0000, clk_ctrl_r};
                SEC_OFS: O_RDATA <= sec_r; // [RULE_02]
                ALARM_OFS: O_RDATA <= alarm_r;
                PIT_CTRL_OFS: O_RDATA <= {16'h0000, pit_ctrl_r};
                PIT_RELOAD_OFS: O_RDATA <= 32'(pit_reload_r); // [RULE_14]
                PIT_COUNT_OFS: O_RDATA <= 32'(pit_count_r); // [RULE_15]
                // The key and unmapped addresses read as zero.
                default: O_RDATA <= WORD_RST;
            endcase
        end
    end

    // Requests are registered so the outputs come from flip-flops.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            O_CLK_IRQ <= '0;
            O_PIT_IRQ <= '0;
        end else begin
            O_CLK_IRQ.req <= (clk_ctrl_r[B_TICK_FLAG] // [RULE_18]
                && clk_ctrl_r[B_TICK_IE])
                || (clk_ctrl_r[B_ALARM_FLAG] && clk_ctrl_r[B_ALARM_IE]); // [RULE_06]
            O_CLK_IRQ.level <= clk_ctrl_r[B_LEVEL_HI:B_LEVEL_LO];
            O_PIT_IRQ.req <= pit_ctrl_r[B_PIT_FLAG] && pit_ctrl_r[B_PIT_IE]; // [RULE_11]
            O_PIT_IRQ.level <= pit_ctrl_r[B_LEVEL_HI:B_LEVEL_LO]; // [RULE_08]
        end
    end

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RESET);

    // A match that was absent and now holds.
    sequence s_match_rise;
        !match ##1 match;
    endsequence

    // A stopped clock with no write leaves the time alone.
    AST_SEC_STOPPED: assert property ( // [RULE_01]
        !clk_ctrl_r[B_CLK_RUN] && !wr_sec |=> $stable(sec_r))
        else $error("seconds moved while disabled");

    // An open write lands in the seconds counter and clears the prescaler.
    AST_SEC_WRITE: assert property ( // [RULE_03]
        wr_sec |=> sec_r == $past(I_BUS.wdata) && pre_r == '0)
        else $error("seconds write not taken cleanly");

    // A locked alarm ignores writes.
    AST_ALARM_LOCKED: assert property ( // [RULE_04]
        I_BUS.wr && I_BUS.addr == ALARM_OFS && !unlocked_r |=> $stable(alarm_r))
        else $error("locked alarm was written");

    // A fresh match sets the alarm flag in the next cycle.
    AST_ALARM_FLAG: assert property ( // [RULE_17]
        s_match_rise |=> clk_ctrl_r[B_ALARM_FLAG])
        else $error("alarm flag missed");

    // An enabled alarm flag reaches the request output.
    AST_ALARM_IRQ: assert property ( // [RULE_06]
        clk_ctrl_r[B_ALARM_FLAG] && clk_ctrl_r[B_ALARM_IE] |=> O_CLK_IRQ.req)
        else $error("alarm request missing");

    // Each tick adds exactly one second.
    AST_SEC_INC: assert property ( // [RULE_22]
        sec_tick && !wr_sec |=> sec_r == $past(sec_r) + 32'h00000001)
        else $error("seconds did not advance by one");

    // Arriving at zero sets the periodic flag.
    AST_PIT_FLAG: assert property ( // [RULE_09]
        pit_evt |=> pit_ctrl_r[B_PIT_FLAG])
        else $error("periodic flag missed");

    // A written one clears the flag when no event competes.
    AST_PIT_CLEAR: assert property ( // [RULE_10]
        wr_pit_ctrl && I_BUS.wdata[B_PIT_FLAG] && !pit_evt |=> !pit_ctrl_r[B_PIT_FLAG])
        else $error("periodic flag not cleared");

    // Flag and enable, with the flag still set a cycle later, give a request in the cycle after.
    AST_PIT_IRQ: assert property ( // [RULE_11]
        pit_ctrl_r[B_PIT_FLAG] && pit_ctrl_r[B_PIT_IE] && !wr_pit_ctrl
        ##1 pit_ctrl_r[B_PIT_FLAG] |=> O_PIT_IRQ.req [*1])
        else $error("periodic request missing");

    // Halted by debug, the count holds.
    AST_PIT_FREEZE: assert property ( // [RULE_12]
        pit_ctrl_r[B_PIT_HALT] && I_FREEZE |=> $stable(pit_count_r))
        else $error("periodic count moved while frozen");

    // A spent count picks up the reload value.
    AST_PIT_RELOAD: assert property ( // [RULE_21]
        pit_step && pit_count_r == '0 |=> pit_count_r == $past(pit_reload_r))
        else $error("periodic reload missed");

    // A count read returns the count with a zero upper half.
    AST_PIT_READ: assert property ( // [RULE_15]
        I_BUS.rd && I_BUS.addr == PIT_COUNT_OFS |=> O_RDATA == 32'($past(pit_count_r)))
        else $error("periodic count read wrong");

    // Debug freeze with the halt bit set holds the seconds.
    AST_CLK_FREEZE: assert property ( // [RULE_22]
        clk_ctrl_r[B_CLK_HALT] && I_FREEZE && !wr_sec |=> $stable(sec_r))
        else $error("seconds moved while frozen");

    // A locked control word keeps its select, enable, halt and run bits.
    AST_CLK_LOCKED: assert property ( // [RULE_04]
        I_BUS.wr && I_BUS.addr == CLK_CTRL_OFS && !unlocked_r
        |=> $stable(clk_ctrl_r[B_CLK_RUN:B_SLOW_SEL]))
        else $error("locked clock control was written");

    // Each one-second tick sets the tick flag.
    AST_TICK_FLAG: assert property ( // [RULE_17]
        sec_tick |=> clk_ctrl_r[B_TICK_FLAG])
        else $error("tick flag missed");

    // An enabled tick flag reaches the request output.
    AST_TICK_IRQ: assert property ( // [RULE_18]
        clk_ctrl_r[B_TICK_FLAG] && clk_ctrl_r[B_TICK_IE] |=> O_CLK_IRQ.req)
        else $error("tick request missing");

    // A stopped periodic timer keeps its count.
    AST_PIT_STOPPED: assert property ( // [RULE_13]
        !pit_ctrl_r[B_PIT_RUN] |=> $stable(pit_count_r))
        else $error("periodic count moved while stopped");

    // A write to the count register leaves the count alone.
    AST_PIT_COUNT_RO: assert property ( // [RULE_15]
        I_BUS.wr && I_BUS.addr == PIT_COUNT_OFS && !pit_step |=> $stable(pit_count_r))
        else $error("periodic count was written");

endmodule

// *** include/scpt_pkg.sv ***
// -----------------------------------------------------------------
// Shared definitions for the seconds clock and periodic timer.
// -----------------------------------------------------------------
package scpt_pkg;

    // Register address width, wide enough for the byte addresses.
    localparam int ADDR_W = 22;
    // Prescaler width, holds the larger one-second division.
    localparam int PRE_W = 25;

    typedef logic [ADDR_W-1:0] scpt_addr_t;

    // One bus request from software.
    typedef struct packed {
        logic wr;
        logic rd;
        scpt_addr_t addr;
        logic [31:0] wdata;
    } scpt_bus_s;

    // One interrupt request with its priority level.
    typedef struct packed {
        logic req;
        logic [7:0] level;
    } scpt_irq_s;

    // Byte addresses of the registers.
    localparam scpt_addr_t CLK_CTRL_OFS = 22'h2fc220;
    localparam scpt_addr_t SEC_OFS = 22'h2fc224;
    localparam scpt_addr_t ALARM_OFS = 22'h2fc22c;
    localparam scpt_addr_t KEY_OFS = 22'h2fc230;
    localparam scpt_addr_t PIT_CTRL_OFS = 22'h2fc240;
    localparam scpt_addr_t PIT_RELOAD_OFS = 22'h2fc244;
    localparam scpt_addr_t PIT_COUNT_OFS = 22'h2fc248;

    // Value that opens the locked registers.
    localparam logic [31:0] KEY_VALUE = 32'h55ccaa33;

    // Field positions of both control words; the level field is common to both.
    localparam int B_LEVEL_LO = 0;
    localparam int B_LEVEL_HI = 7;
    localparam int B_TICK_FLAG = 8;
    localparam int B_ALARM_FLAG = 9;
    localparam int B_SLOW_SEL = 11;
    localparam int B_TICK_IE = 12;
    localparam int B_ALARM_IE = 13;
    localparam int B_CLK_HALT = 14;
    localparam int B_CLK_RUN = 15;
    localparam int B_PIT_FLAG = 8;
    localparam int B_PIT_IE = 13;
    localparam int B_PIT_HALT = 14;
    localparam int B_PIT_RUN = 15;

    // Values after reset.
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [31:0] WORD_RST = 32'h00000000;

    // One-second tick in oscillator periods for each source rate.
    localparam int TICK_PERIOD_S = 1;
    localparam int FAST_OSC_HZ = 20_000_000;
    localparam int SLOW_OSC_HZ = 4_000_000;
    localparam int FAST_TICK_CYC = TICK_PERIOD_S * FAST_OSC_HZ;
    localparam int SLOW_TICK_CYC = TICK_PERIOD_S * SLOW_OSC_HZ;

endpackage

// *** verification/test_scpt_top.sv ***
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Self-checking bench for the seconds clock and periodic timer.
// -----------------------------------------------------------------
module test_scpt_top;
    import scpt_pkg::*;

    // Small prescaler divisions keep the one-second tick short.
    localparam int unsigned FAST_DIV = 10;
    localparam int unsigned SLOW_DIV = 4;

    logic i_sys_clk = 1'b0; // Bench clock, 40 ns period.
    logic i_reset = 1'b1; // Synchronous reset, active high.
    scpt_bus_s bus = '0; // Register bus request.
    logic osc_tick = 1'b0; // Oscillator period enable.
    logic freeze = 1'b0; // Debug freeze level.
    logic [31:0] rdata; // Read data from the block.
    scpt_irq_s clk_irq; // Seconds-clock request.
    scpt_irq_s pit_irq; // Periodic request.
    int fail_count = 0; // Mismatches seen.
    int num_checks = 0; // Comparisons made.

    scpt_top #(.P_FAST_DIV(FAST_DIV), .P_SLOW_DIV(SLOW_DIV), .PIT_W(16)) scpt_top_inst (
        .I_SYS_CLK(i_sys_clk),
        .I_RESET(i_reset),
        .I_BUS(bus),
        .I_OSC_TICK(osc_tick),
        .I_FREEZE(freeze),
        .O_RDATA(rdata),
        .O_CLK_IRQ(clk_irq),
        .O_PIT_IRQ(pit_irq)
    );

    // The clock toggles every half period.
    always #20 i_sys_clk = ~i_sys_clk;

    // -----------------------------------------------------------------
    // Closing, comparison, bus and oscillator tasks.
    // -----------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Compares one 32-bit word with case equality.
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Compares one request output: the request bit and its priority level.
    task automatic chk_irq(input scpt_irq_s got, input scpt_irq_s exp);
        chk_word({23'h0, got}, {23'h0, exp});
    endtask

    // One-cycle write strobe beside address and data.
    task automatic wr(input scpt_addr_t addr, input logic [31:0] data);
        @(posedge i_sys_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge i_sys_clk);
        bus <= '0;
    endtask

    // One-cycle read strobe; data are sampled in the single cycle they stand.
    task automatic rd_chk(input scpt_addr_t addr, input logic [31:0] exp);
        @(posedge i_sys_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h0};
        @(posedge i_sys_clk);
        bus <= '0;
        #1;
        chk_word(rdata, exp);
    endtask

    // Sends n oscillator enables, two cycles apart.
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge i_sys_clk);
            osc_tick <= 1'b1;
            @(posedge i_sys_clk);
            osc_tick <= 1'b0;
        end
    endtask

    // Lets flags and requests settle, then checks both requests.
    task automatic irq_chk(input scpt_irq_s exp_clk, input scpt_irq_s exp_pit);
        repeat (3) @(posedge i_sys_clk);
        #1;
        chk_irq(clk_irq, exp_clk);
        chk_irq(pit_irq, exp_pit);
    endtask

    // A hang is cut short well beyond the few hundred cycles needed.
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        fail_count++;
        conclude();
    end

    // -----------------------------------------------------------------
    // Main sequence.
    // -----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        @(posedge i_sys_clk);
        // Reset values and an unmapped place.
        rd_chk(PIT_CTRL_OFS, 32'h0);
        rd_chk(PIT_RELOAD_OFS, 32'h0);
        rd_chk(PIT_COUNT_OFS, 32'h0);
        rd_chk(CLK_CTRL_OFS, 32'h0);
        rd_chk(22'h2fc2f0, 32'h0);
        // Locked registers ignore writes until the key is given.
        wr(SEC_OFS, 32'h5);
        wr(ALARM_OFS, 32'h9);
        rd_chk(SEC_OFS, 32'h0);
        rd_chk(ALARM_OFS, 32'h0);
        wr(KEY_OFS, KEY_VALUE);
        wr(SEC_OFS, 32'hdeadbeef);
        rd_chk(SEC_OFS, 32'hdeadbeef);
        // Periodic counter: reserved reload bits read zero.
        wr(PIT_RELOAD_OFS, 32'hffff0003);
        rd_chk(PIT_RELOAD_OFS, 32'h00000003);
        wr(PIT_CTRL_OFS, 32'h0000a05a);
        ticks(2);
        rd_chk(PIT_COUNT_OFS, 32'h2);
        ticks(2);
        rd_chk(PIT_CTRL_OFS, 32'h0000a15a);
        irq_chk('{req: 1'b0, level: 8'h00}, '{req: 1'b1, level: 8'h5a});
        // A written zero keeps the flag, a written one clears it.
        wr(PIT_CTRL_OFS, 32'h0000a05a);
        rd_chk(PIT_CTRL_OFS, 32'h0000a15a);
        wr(PIT_CTRL_OFS, 32'h0000a15a);
        rd_chk(PIT_CTRL_OFS, 32'h0000a05a);
        irq_chk('{req: 1'b0, level: 8'h00}, '{req: 1'b0, level: 8'h5a});
        ticks(1);
        rd_chk(PIT_COUNT_OFS, 32'h3);
        // Freeze holds the count while the halt bit is set; released, the count moves on.
        wr(PIT_CTRL_OFS, 32'h0000e05a);
        freeze <= 1'b1;
        ticks(2);
        rd_chk(PIT_COUNT_OFS, 32'h3);
        @(posedge i_sys_clk);
        freeze <= 1'b0;
        ticks(1);
        rd_chk(PIT_COUNT_OFS, 32'h2);
        wr(PIT_CTRL_OFS, 32'h0000405a);
        ticks(2);
        wr(PIT_COUNT_OFS, 32'h00001234);
        rd_chk(PIT_COUNT_OFS, 32'h2);
        // Seconds counter on the fast division.
        wr(CLK_CTRL_OFS, 32'h00009033);
        wr(SEC_OFS, 32'h7);
        ticks(FAST_DIV - 1);
        rd_chk(SEC_OFS, 32'h7);
        ticks(1);
        rd_chk(SEC_OFS, 32'h8);
        rd_chk(CLK_CTRL_OFS, 32'h00009133);
        irq_chk('{req: 1'b1, level: 8'h33}, '{req: 1'b0, level: 8'h5a});
        // A seconds write restarts the sub-second count.
        ticks(5);
        wr(SEC_OFS, 32'h7);
        ticks(FAST_DIV - 1);
        rd_chk(SEC_OFS, 32'h7);
        ticks(1);
        rd_chk(SEC_OFS, 32'h8);
        // Run off: flag cleared by its one, counter stands.
        wr(CLK_CTRL_OFS, 32'h00000100);
        rd_chk(CLK_CTRL_OFS, 32'h0);
        ticks(FAST_DIV);
        rd_chk(SEC_OFS, 32'h8);
        irq_chk('{req: 1'b0, level: 8'h00}, '{req: 1'b0, level: 8'h5a});
        // Alarm on the slow division; only the alarm request is enabled.
        wr(SEC_OFS, 32'h14);
        wr(ALARM_OFS, 32'h15);
        rd_chk(ALARM_OFS, 32'h15);
        wr(CLK_CTRL_OFS, 32'h0000a811);
        ticks(SLOW_DIV - 1);
        rd_chk(CLK_CTRL_OFS, 32'h0000a811);
        ticks(1);
        rd_chk(SEC_OFS, 32'h15);
        rd_chk(CLK_CTRL_OFS, 32'h0000ab11);
        irq_chk('{req: 1'b1, level: 8'h11}, '{req: 1'b0, level: 8'h5a});
        // Both flags cleared in one write drop the request.
        wr(CLK_CTRL_OFS, 32'h0000ab11);
        rd_chk(CLK_CTRL_OFS, 32'h0000a811);
        irq_chk('{req: 1'b0, level: 8'h11}, '{req: 1'b0, level: 8'h5a});
        // Debug freeze holds the seconds while the halt bit is set.
        wr(CLK_CTRL_OFS, 32'h0000c811);
        freeze <= 1'b1;
        ticks(SLOW_DIV);
        rd_chk(SEC_OFS, 32'h15);
        @(posedge i_sys_clk);
        freeze <= 1'b0;
        ticks(SLOW_DIV);
        rd_chk(SEC_OFS, 32'h16);
        // A second reset clears the registers and closes the lock again.
        @(posedge i_sys_clk);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        @(posedge i_sys_clk);
        rd_chk(PIT_CTRL_OFS, 32'h0);
        rd_chk(SEC_OFS, 32'h0);
        rd_chk(CLK_CTRL_OFS, 32'h0);
        irq_chk('{req: 1'b0, level: 8'h00}, '{req: 1'b0, level: 8'h00});
        wr(CLK_CTRL_OFS, 32'h00008000);
        rd_chk(CLK_CTRL_OFS, 32'h0);
        // Any value other than the key closes the lock once more.
        wr(KEY_OFS, KEY_VALUE);
        wr(KEY_OFS, 32'h0);
        wr(ALARM_OFS, 32'h3);
        rd_chk(ALARM_OFS, 32'h0);
        conclude();
    end
endmodule
